// ### verilog/pmd_pkg.sv
package pmd_pkg;

   // Register map (byte addresses, low address byte only)
   localparam int ADDR_WIDTH = 8;
   localparam logic [7:0] MODULE_DISABLE_ONE_OFFSET = 8'hC0;
   localparam logic [7:0] CLEAR_ALIAS_OFFSET = 8'hC4;
   localparam logic [7:0] SET_ALIAS_OFFSET = 8'hC8;
   localparam logic [7:0] INVERT_ALIAS_OFFSET = 8'hCC;
   localparam logic [7:0] CONFIG_CONTROL_ZERO_OFFSET = 8'hD0;
   localparam logic [7:0] ENABLE_STATUS_OFFSET = 8'hD4;

   // Fields
   localparam int LOCK_BIT = 0;
   localparam logic LOCK_RESET = 1'h0;
   localparam logic [31:0] MODULE_DISABLE_ONE_RESET = 32'h0000_0000;
   localparam logic [31:0] MODULE_DISABLE_ONE_MASK = 32'h2001_01DF;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // Bit positions of the disable bits
   localparam int RADIO_15_4_DISABLE_BIT = 0;
   localparam int SHORT_RANGE_RADIO_DISABLE_BIT = 1;
   localparam int MID_POWER_AMP_DISABLE_BIT = 2;
   localparam int LOW_POWER_AMP_DISABLE_BIT = 3;
   localparam int SUPPLY_LEVEL_DETECT_DISABLE_BIT = 4;
   localparam int COMPARATOR_DISABLE_BIT = 6;
   localparam int CONVERTER_CTRL_DISABLE_BIT = 7;
   localparam int CONVERTER_CORE_DISABLE_BIT = 8;
   localparam int CALENDAR_COUNTER_DISABLE_BIT = 16;
   localparam int QUAD_SERIAL_DISABLE_BIT = 29;

   // Channel order: one gated peripheral per channel
   localparam int CHANNELS = 10;
   localparam int CHANNEL_BIT [CHANNELS] = '{
      RADIO_15_4_DISABLE_BIT, SHORT_RANGE_RADIO_DISABLE_BIT, MID_POWER_AMP_DISABLE_BIT,
      LOW_POWER_AMP_DISABLE_BIT, SUPPLY_LEVEL_DETECT_DISABLE_BIT, COMPARATOR_DISABLE_BIT,
      CONVERTER_CTRL_DISABLE_BIT, CONVERTER_CORE_DISABLE_BIT, CALENDAR_COUNTER_DISABLE_BIT,
      QUAD_SERIAL_DISABLE_BIT};
   // Channels that also carry an internal module enable: comparator, calendar, quad serial
   localparam logic [CHANNELS-1:0] HAS_MODULE_CTRL = 10'h320;
   localparam logic [CHANNELS-1:0] CHANNELS_ZERO = 10'h000;

   // Debug service unit, event system, access controller
   localparam int ALWAYS_ON_UNITS = 3;
   localparam logic [ALWAYS_ON_UNITS-1:0] ALWAYS_ON_VALUE = 3'h7;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;
   localparam logic HREADY_ON = 1'h1;

   typedef enum logic [1:0] {
      ALIAS_DIRECT = 2'h0,
      ALIAS_CLEAR = 2'h1,
      ALIAS_SET = 2'h3,
      ALIAS_INVERT = 2'h2
   } alias_op_type;

endpackage

// ### verilog/pmd_alias_update.sv
`timescale 1ns/1ns
module pmd_alias_update (
   input wire logic [31:0] old_value,
   input wire logic [31:0] write_data,
   input wire pmd_pkg::alias_op_type op,
   input wire logic write_enable,
   input wire logic locked,
   output logic [31:0] new_value
);

   always_comb begin
      new_value = old_value;
      if (write_enable && !locked) begin
         case (op)
            pmd_pkg::ALIAS_DIRECT: new_value = write_data;
            pmd_pkg::ALIAS_CLEAR: new_value = old_value & ~write_data;
            pmd_pkg::ALIAS_SET: new_value = old_value | write_data;
            pmd_pkg::ALIAS_INVERT: new_value = old_value ^ write_data;
            default: new_value = old_value;
         endcase
         // Unimplemented bits never store a one
         new_value = new_value & pmd_pkg::MODULE_DISABLE_ONE_MASK;
      end
   end

endmodule

// ### verilog/pmd_channel.sv
`timescale 1ns/1ns
module pmd_channel #(
   parameter bit HAS_MODULE_CTRL = 1'b0
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic disable_bit,
   input wire logic module_enable,
   output logic bus_clock_enable,
   output logic gen_clock_enable,
   output logic reset_n,
   output logic visible,
   output logic enable_out
);

   logic next_bus_clock_enable;
   logic next_gen_clock_enable;
   logic next_reset_n;
   logic next_visible;
   logic next_enable_out;

   always_comb begin
      next_bus_clock_enable = !disable_bit;
      next_gen_clock_enable = !disable_bit;
      next_reset_n = !disable_bit;
      next_visible = !disable_bit;
      // Internal enable only matters where the module has one
      if (HAS_MODULE_CTRL) begin
         next_enable_out = !disable_bit && module_enable;
      end else begin
         next_enable_out = !disable_bit;
      end
   end

   // Peripheral stays in reset while the system reset is asserted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_clock_enable <= 1'b1;
         gen_clock_enable <= 1'b1;
         reset_n <= 1'b0;
         visible <= 1'b0;
         enable_out <= 1'b0;
      end else begin
         bus_clock_enable <= next_bus_clock_enable;
         gen_clock_enable <= next_gen_clock_enable;
         reset_n <= next_reset_n;
         visible <= next_visible;
         enable_out <= next_enable_out;
      end
   end

endmodule

// ### verilog/peripheral_module_disable.sv
`timescale 1ns/1ns
// How it works
// - Disable bit at zero leaves the peripheral enabled and running as configured.
// - Disable bit at one hides the peripheral and holds it in reset.
// - With the lock bit set, writes to the disable registers are ignored.
// - Clear, set and invert aliases sit at offsets 0x4, 0x8, 0xC.
// - A set disable bit stops both bus clock and generic clock.
// - Effective enable is disable bit zero, AND module enable one where the peripheral has one.
// - Comparator, calendar and quad serial need both; either alone disables.
// - Debug service, event system, access controller are always enabled.
// - Disable bit map: radios 0-1, amps 2-3, detect 4, comparator 6, converter 7-8.
// - Lock bit is one-way: only a reset clears it.
module peripheral_module_disable (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [pmd_pkg::CHANNELS-1:0] module_enable,
   output logic [pmd_pkg::CHANNELS-1:0] peripheral_bus_clock_enable,
   output logic [pmd_pkg::CHANNELS-1:0] generic_clock_enable,
   output logic [pmd_pkg::CHANNELS-1:0] peripheral_reset_n,
   output logic [pmd_pkg::CHANNELS-1:0] peripheral_visible,
   output logic [pmd_pkg::CHANNELS-1:0] effective_enable,
   output logic [pmd_pkg::ALWAYS_ON_UNITS-1:0] always_enabled,
   output logic disable_reg_write_lock
);

   logic [31:0] module_disable_one;
   logic [31:0] next_module_disable_one;
   logic next_disable_reg_write_lock;
   logic data_write;
   logic next_data_write;
   logic [pmd_pkg::ADDR_WIDTH-1:0] data_addr;
   logic [pmd_pkg::ADDR_WIDTH-1:0] next_data_addr;
   logic [31:0] next_hrdata;
   logic next_hreadyout;
   logic next_hresp;
   logic [pmd_pkg::ALWAYS_ON_UNITS-1:0] next_always_enabled;
   logic address_phase;
   logic disable_hit;
   pmd_pkg::alias_op_type write_op;
   logic [pmd_pkg::CHANNELS-1:0] channel_disable;
   logic [pmd_pkg::ADDR_WIDTH-1:0] read_addr;

   // Bus address phase and data-phase capture
   always_comb begin
      address_phase = hsel && htrans[1] && hready;
      read_addr = haddr[pmd_pkg::ADDR_WIDTH-1:0];
      next_data_write = address_phase && hwrite;
      next_data_addr = data_addr;
      if (address_phase) begin
         next_data_addr = haddr[pmd_pkg::ADDR_WIDTH-1:0];
      end
      // No wait states: the slave is always ready and always answers OKAY
      next_hreadyout = pmd_pkg::HREADY_ON;
      next_hresp = pmd_pkg::HRESP_OKAY;
   end

   // Decode of the disable register and its three aliases
   always_comb begin
      disable_hit = 1'b1;
      write_op = pmd_pkg::ALIAS_DIRECT;
      case (data_addr)
         pmd_pkg::MODULE_DISABLE_ONE_OFFSET: begin
            write_op = pmd_pkg::ALIAS_DIRECT;
         end
         pmd_pkg::CLEAR_ALIAS_OFFSET: begin
            write_op = pmd_pkg::ALIAS_CLEAR;
         end
         pmd_pkg::SET_ALIAS_OFFSET: begin
            write_op = pmd_pkg::ALIAS_SET;
         end
         pmd_pkg::INVERT_ALIAS_OFFSET: begin
            write_op = pmd_pkg::ALIAS_INVERT;
         end
         default: begin
            disable_hit = 1'b0;
         end
      endcase
   end

   pmd_alias_update u_alias_update (
      .old_value(module_disable_one),
      .write_data(hwdata),
      .op(write_op),
      .write_enable(data_write && disable_hit),
      .locked(disable_reg_write_lock),
      .new_value(next_module_disable_one)
   );

   // Lock can only be set by software; reset is the only way back
   always_comb begin
      next_disable_reg_write_lock = disable_reg_write_lock;
      if (data_write && data_addr == pmd_pkg::CONFIG_CONTROL_ZERO_OFFSET && hwdata[pmd_pkg::LOCK_BIT]) begin
         next_disable_reg_write_lock = 1'b1;
      end
   end

   // Disable and lock read data come from the next values so a write just landing is seen; status reads the current enables
   always_comb begin
      next_hrdata = pmd_pkg::READ_ZERO;
      if (address_phase && !hwrite) begin
         case (read_addr)
            pmd_pkg::MODULE_DISABLE_ONE_OFFSET: begin
               next_hrdata = next_module_disable_one;
            end
            pmd_pkg::CONFIG_CONTROL_ZERO_OFFSET: begin
               next_hrdata[pmd_pkg::LOCK_BIT] = next_disable_reg_write_lock;
            end
            pmd_pkg::ENABLE_STATUS_OFFSET: begin
               next_hrdata[pmd_pkg::CHANNELS-1:0] = effective_enable;
            end
            default: begin
               next_hrdata = pmd_pkg::READ_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         module_disable_one <= pmd_pkg::MODULE_DISABLE_ONE_RESET;
         disable_reg_write_lock <= pmd_pkg::LOCK_RESET;
         data_write <= 1'b0;
         data_addr <= '0;
         hrdata <= pmd_pkg::READ_ZERO;
         hreadyout <= pmd_pkg::HREADY_ON;
         hresp <= pmd_pkg::HRESP_OKAY;
      end else begin
         module_disable_one <= next_module_disable_one;
         disable_reg_write_lock <= next_disable_reg_write_lock;
         data_write <= next_data_write;
         data_addr <= next_data_addr;
         hrdata <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp <= next_hresp;
      end
   end

   // One gate per peripheral, picked out of the disable register by bit position
   generate
      for (genvar i = 0; i < pmd_pkg::CHANNELS; i++) begin : g_channel
         assign channel_disable[i] = module_disable_one[pmd_pkg::CHANNEL_BIT[i]];
         pmd_channel #(
            .HAS_MODULE_CTRL(pmd_pkg::HAS_MODULE_CTRL[i])
         ) u_channel (
            .hclk(hclk),
            .hresetn(hresetn),
            .disable_bit(channel_disable[i]),
            .module_enable(module_enable[i]),
            .bus_clock_enable(peripheral_bus_clock_enable[i]),
            .gen_clock_enable(generic_clock_enable[i]),
            .reset_n(peripheral_reset_n[i]),
            .visible(peripheral_visible[i]),
            .enable_out(effective_enable[i])
         );
      end
   endgenerate

   // These units have no disable bit and no module enable at all
   always_comb begin
      next_always_enabled = pmd_pkg::ALWAYS_ON_VALUE;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         always_enabled <= pmd_pkg::ALWAYS_ON_VALUE;
      end else begin
         always_enabled <= next_always_enabled;
      end
   end

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_unlocked_write(logic [7:0] addr);
      data_write && data_addr == addr && !disable_reg_write_lock;
   endsequence

   sequence s_locked_disable_write;
      data_write && disable_reg_write_lock && disable_hit;
   endsequence

   sequence s_lock_request;
      data_write && data_addr == pmd_pkg::CONFIG_CONTROL_ZERO_OFFSET && hwdata[pmd_pkg::LOCK_BIT];
   endsequence

   a_locked_write_ignored: assert property (
      s_locked_disable_write |=> $stable(module_disable_one))
      else $error("disable register changed while locked");

   a_lock_sets: assert property (
      s_lock_request |=> disable_reg_write_lock [*8])
      else $error("lock bit not held after being set");

   a_lock_one_way: assert property (
      disable_reg_write_lock |=> disable_reg_write_lock)
      else $error("lock bit fell without reset");

   a_direct_write: assert property (
      s_unlocked_write(pmd_pkg::MODULE_DISABLE_ONE_OFFSET)
      |=> module_disable_one == ($past(hwdata) & pmd_pkg::MODULE_DISABLE_ONE_MASK))
      else $error("direct write not stored");

   a_clear_alias: assert property (
      s_unlocked_write(pmd_pkg::CLEAR_ALIAS_OFFSET)
      |=> module_disable_one == ($past(module_disable_one) & ~$past(hwdata)))
      else $error("clear alias wrong");

   a_set_alias: assert property (
      s_unlocked_write(pmd_pkg::SET_ALIAS_OFFSET)
      |=> module_disable_one == (($past(module_disable_one) | $past(hwdata)) & pmd_pkg::MODULE_DISABLE_ONE_MASK))
      else $error("set alias wrong");

   a_invert_alias: assert property (
      s_unlocked_write(pmd_pkg::INVERT_ALIAS_OFFSET)
      |=> module_disable_one == (($past(module_disable_one) ^ $past(hwdata)) & pmd_pkg::MODULE_DISABLE_ONE_MASK))
      else $error("invert alias wrong");

   a_clocks_gated: assert property (
      1'b1 |=> ((peripheral_bus_clock_enable | generic_clock_enable) & $past(channel_disable))
               == pmd_pkg::CHANNELS_ZERO)
      else $error("clock runs for a disabled peripheral");

   a_disabled_hidden: assert property (
      1'b1 |=> ((peripheral_reset_n | peripheral_visible | effective_enable) & $past(channel_disable))
               == pmd_pkg::CHANNELS_ZERO)
      else $error("disabled peripheral visible or out of reset");

   a_enabled_runs: assert property (
      1'b1 |=> (~(peripheral_reset_n & peripheral_visible & peripheral_bus_clock_enable) & ~$past(channel_disable))
               == pmd_pkg::CHANNELS_ZERO)
      else $error("enabled peripheral held off");

   a_both_controls: assert property (
      1'b1 |=> effective_enable
               == $past(~channel_disable & (module_enable | ~pmd_pkg::HAS_MODULE_CTRL)))
      else $error("effective enable does not combine both controls");

   a_always_on: assert property (
      always_enabled == pmd_pkg::ALWAYS_ON_VALUE)
      else $error("always-on unit switched off");

   a_unused_bits_zero: assert property (
      (module_disable_one & ~pmd_pkg::MODULE_DISABLE_ONE_MASK) == pmd_pkg::READ_ZERO)
      else $error("unimplemented disable bit set");

   a_bus_okay: assert property (
      hreadyout && hresp == pmd_pkg::HRESP_OKAY)
      else $error("slave stalled or answered an error");

   // Read path: the disable and lock words in the data phase must match the stored state after the same edge, status the state before it
   sequence s_read_of(logic [7:0] addr);
      address_phase && !hwrite && read_addr == addr;
   endsequence

   a_disable_readback: assert property (
      s_read_of(pmd_pkg::MODULE_DISABLE_ONE_OFFSET) |=> hrdata == module_disable_one)
      else $error("disable register read back wrong");

   a_lock_readback: assert property (
      s_read_of(pmd_pkg::CONFIG_CONTROL_ZERO_OFFSET) |=> hrdata == {31'h0000_0000, disable_reg_write_lock})
      else $error("lock bit read back wrong");

   a_status_readback: assert property (
      s_read_of(pmd_pkg::ENABLE_STATUS_OFFSET) |=> hrdata == {22'h00_0000, $past(effective_enable)})
      else $error("enable status read back wrong");

   // Aliases are write-only views, so a read must not leak the register
   a_alias_reads_zero: assert property (
      address_phase && !hwrite
      && (read_addr == pmd_pkg::CLEAR_ALIAS_OFFSET || read_addr == pmd_pkg::SET_ALIAS_OFFSET
          || read_addr == pmd_pkg::INVERT_ALIAS_OFFSET)
      |=> hrdata == pmd_pkg::READ_ZERO)
      else $error("alias read returned data");

   a_idle_read_zero: assert property (
      !(address_phase && !hwrite) |=> hrdata == pmd_pkg::READ_ZERO)
      else $error("read data held outside a read");

   // Only the disable register and its aliases may move its contents
   a_other_writes_ignored: assert property (
      data_write && !disable_hit |=> $stable(module_disable_one))
      else $error("disable register changed by another address");

   // Peripherals without an enable of their own follow the disable bit alone
   a_plain_channels: assert property (
      1'b1 |=> (effective_enable & ~pmd_pkg::HAS_MODULE_CTRL)
               == (~$past(channel_disable) & ~pmd_pkg::HAS_MODULE_CTRL))
      else $error("plain channel enable wrong");

endmodule

// ### bench/peripheral_far_model.sv
`timescale 1ns/1ns
module peripheral_far_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [pmd_pkg::CHANNELS-1:0] peripheral_reset_n,
   input wire logic [pmd_pkg::CHANNELS-1:0] peripheral_bus_clock_enable,
   input wire logic [pmd_pkg::CHANNELS-1:0] enable_request,
   output logic [pmd_pkg::CHANNELS-1:0] module_enable
);
   // A peripheral held in reset or without its bus clock cannot keep its own enable,
   // so software must clear the disable bit first and then program the module enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         module_enable <= '0;
      end else begin
         module_enable <= enable_request & peripheral_reset_n & peripheral_bus_clock_enable;
      end
   end
endmodule

// ### bench/test_peripheral_module_disable.sv
`timescale 1ns/1ns
module test_peripheral_module_disable;
   localparam int N = pmd_pkg::CHANNELS;
   localparam logic [7:0] A_DIS = pmd_pkg::MODULE_DISABLE_ONE_OFFSET;
   localparam logic [7:0] A_CFG = pmd_pkg::CONFIG_CONTROL_ZERO_OFFSET;
   localparam logic [7:0] A_STS = pmd_pkg::ENABLE_STATUS_OFFSET;
   localparam logic [31:0] MASK = pmd_pkg::MODULE_DISABLE_ONE_MASK;
   localparam logic [7:0] AL_ADDR [4] = '{A_DIS, pmd_pkg::CLEAR_ALIAS_OFFSET,
      pmd_pkg::SET_ALIAS_OFFSET, pmd_pkg::INVERT_ALIAS_OFFSET};
   localparam logic [31:0] AL_DATA [4] = '{32'h0000_0055, 32'h0000_0005, 32'h2000_0001, 32'h0001_0011};
   localparam logic [31:0] AL_EXP [4] = '{32'h0000_0055, 32'h0000_0050, 32'h2000_0051, 32'h2001_0040};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready, hreadyout, hresp, lock;
   logic [31:0] hrdata, rd;
   logic [N-1:0] module_enable, bus_clk_en, gen_clk_en, rst_n, visible, eff_en;
   logic [N-1:0] enable_request = '0;
   logic [2:0] always_on;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;

   assign hready = hreadyout;

   initial begin
      forever #5 hclk = ~hclk;
   end

   peripheral_module_disable DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .module_enable(module_enable),
      .peripheral_bus_clock_enable(bus_clk_en), .generic_clock_enable(gen_clk_en),
      .peripheral_reset_n(rst_n), .peripheral_visible(visible), .effective_enable(eff_en),
      .always_enabled(always_on), .disable_reg_write_lock(lock));

   peripheral_far_model far_side (
      .hclk(hclk), .hresetn(hresetn), .peripheral_reset_n(rst_n),
      .peripheral_bus_clock_enable(bus_clk_en), .enable_request(enable_request),
      .module_enable(module_enable));

   task automatic close_out();
      $display("Errors %0d in %0d checks", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t word got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk10(input logic [N-1:0] got, input logic [N-1:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t channels got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // One single transfer; both phases wait on hready, though this slave never stretches either
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= pmd_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      chk32({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk32(rd, exp);
   endtask

   function automatic logic [N-1:0] chan(input logic [31:0] v);
      logic [N-1:0] c;
      for (int i = 0; i < N; i++) begin
         c[i] = v[pmd_pkg::CHANNEL_BIT[i]];
      end
      return c;
   endfunction

   // Outputs are sampled at a rising edge, so they show the value of the cycle before it
   task automatic chans(input logic [31:0] dis, input logic [N-1:0] men);
      logic [N-1:0] on;
      on = ~chan(dis);
      chk10(bus_clk_en, on);
      chk10(gen_clk_en, on);
      chk10(rst_n, on);
      chk10(visible, on);
      chk10(eff_en, on & (men | ~pmd_pkg::HAS_MODULE_CTRL));
      chk32({29'h0000_0000, always_on}, 32'h0000_0007);
   endtask

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         close_out();
      end
   end

   initial begin
      settle(3);
      chk10(rst_n, '0);
      chk32({29'h0000_0000, always_on}, 32'h0000_0007);
      hresetn <= 1'b1;
      settle(2);
      chans(32'h0000_0000, '0);
      rdchk(A_DIS, 32'h0000_0000);
      rdchk(A_CFG, 32'h0000_0000);
      xfer(1'b1, A_DIS, 32'hFFFF_FFFF);
      rdchk(A_DIS, MASK);
      chans(MASK, '0);
      for (int i = 0; i < N; i++) begin
         xfer(1'b1, A_DIS, 32'h0000_0001 << pmd_pkg::CHANNEL_BIT[i]);
         rdchk(A_DIS, 32'h0000_0001 << pmd_pkg::CHANNEL_BIT[i]);
         chans(32'h0000_0001 << pmd_pkg::CHANNEL_BIT[i], '0);
      end
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, AL_ADDR[i], AL_DATA[i]);
         rdchk(A_DIS, AL_EXP[i]);
         chans(AL_EXP[i], '0);
      end
      rdchk(pmd_pkg::INVERT_ALIAS_OFFSET, 32'h0000_0000);
      xfer(1'b1, A_DIS, 32'h0000_0000);
      // The far side keeps its enable only after its reset lifts, and the gate adds one more edge
      enable_request <= '1;
      settle(4);
      chans(32'h0000_0000, '1);
      rdchk(A_STS, 32'h0000_03FF);
      // Modules are switched off before any disable bit is set
      enable_request <= '0;
      settle(3);
      chans(32'h0000_0000, '0);
      rdchk(A_STS, 32'h0000_00DF);
      enable_request <= '1;
      settle(3);
      xfer(1'b1, pmd_pkg::SET_ALIAS_OFFSET, 32'h0000_0040);
      rdchk(A_DIS, 32'h0000_0040);
      chans(32'h0000_0040, '1);
      xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
      rdchk(8'h10, 32'h0000_0000);
      xfer(1'b1, A_STS, 32'h0000_0000);
      rdchk(A_STS, 32'h0000_03DF);
      xfer(1'b1, A_CFG, 32'h0000_0001);
      rdchk(A_CFG, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, AL_ADDR[i], 32'hFFFF_FFFF);
         rdchk(A_DIS, 32'h0000_0040);
      end
      xfer(1'b1, A_CFG, 32'h0000_0000);
      rdchk(A_CFG, 32'h0000_0001);
      chk32({31'h0000_0000, lock}, 32'h0000_0001);
      chans(32'h0000_0040, '1);
      // Reset in mid-run is the only way out of the lock
      hresetn <= 1'b0;
      settle(2);
      chk10(rst_n, '0);
      hresetn <= 1'b1;
      settle(2);
      chk32({31'h0000_0000, lock}, 32'h0000_0000);
      rdchk(A_CFG, 32'h0000_0000);
      rdchk(A_DIS, 32'h0000_0000);
      xfer(1'b1, pmd_pkg::SET_ALIAS_OFFSET, 32'h0000_0001);
      rdchk(A_DIS, 32'h0000_0001);
      // Enable requests are still raised, so the far side has re-armed its enables by now
      chans(32'h0000_0001, '1);
      close_out();
   end
endmodule
